// [rtl/expansion_valve_drive.sv]
`timescale 1ns/1ps
module expansion_valve_drive #(
   parameter int unsigned STEP_CYCLES = valve_step_pkg::STEP_CYCLES,
   parameter int unsigned HOME_STEPS  = valve_step_pkg::HOME_STEPS
) (
   input  wire logic                     clk_sys,
   input  wire logic                     nrst,
   input  wire valve_step_pkg::pos_cmd_t cmd,
   output logic [3:0]                    coil,
   output logic signed [15:0]            position,
   output logic                          busy,
   output logic                          homed
);

   ////////////////////////////////////////////////////////////////////////////
   // State and counters.
   valve_step_pkg::drive_state_t state_r;
   logic [31:0]                  tick_r;
   logic [15:0]                  home_cnt_r;
   logic [1:0]                   phase_r;
   logic signed [15:0]           pos_r;
   logic signed [15:0]           target_r;
   logic [3:0]                   coil_r;
   logic                         drive_en_r;
   logic                         step_due;
   logic                         dir_close;

   // The interval counter gives one step every STEP_CYCLES cycles.
   assign step_due  = (tick_r == 32'(STEP_CYCLES - 1));
   // Closing direction lowers the position count.
   assign dir_close = (target_r < pos_r);

   ////////////////////////////////////////////////////////////////////////////
   // Step interval timer, restarted whenever the drive is idle.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tick_r <= 32'h0;
      end else if (state_r == valve_step_pkg::ST_IDLE || step_due) begin
         tick_r <= 32'h0;
      end else begin
         tick_r <= tick_r + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: homing, then target tracking; commands during homing are dropped.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_r    <= valve_step_pkg::ST_HOME;
         home_cnt_r <= 16'h0;
         // The rotor is taken to rest one closing step behind pattern 1.
         phase_r    <= 2'h3;
         pos_r      <= valve_step_pkg::POS_CLOSED;
         target_r   <= valve_step_pkg::POS_CLOSED;
      end else begin
         if (cmd.valid && state_r != valve_step_pkg::ST_HOME) begin
            target_r <= cmd.target;
         end
         case (state_r)
            valve_step_pkg::ST_HOME: begin
               // The last homing pattern is held for one full interval before release,
               // so the motor sees every one of the homing steps.
               if (step_due) begin
                  if (home_cnt_r == 16'(HOME_STEPS)) begin
                     pos_r   <= valve_step_pkg::POS_CLOSED;
                     state_r <= valve_step_pkg::ST_IDLE;
                  end else begin
                     phase_r    <= phase_r + 2'h1;
                     home_cnt_r <= home_cnt_r + 16'h1;
                  end
               end
            end
            valve_step_pkg::ST_IDLE: begin
               if (target_r != pos_r) begin
                  state_r <= valve_step_pkg::ST_MOVE;
               end
            end
            valve_step_pkg::ST_MOVE: begin
               if (target_r == pos_r) begin
                  state_r <= valve_step_pkg::ST_IDLE;
               end else if (step_due) begin
                  // One neighbour state per step, so no pattern is skipped.
                  if (dir_close) begin
                     phase_r <= phase_r + 2'h1;
                     pos_r   <= pos_r - 16'sh1;
                  end else begin
                     phase_r <= phase_r - 2'h1;
                     pos_r   <= pos_r + 16'sh1;
                  end
               end
            end
            default: state_r <= valve_step_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Drive enable: a run keeps the coils off until its first step. Re-energizing the held
   // phase at once would jerk the rotor if it settled elsewhere, so the first pattern of a
   // run is always a neighbour of the one last driven.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         drive_en_r <= 1'b0;
      end else if (state_r == valve_step_pkg::ST_IDLE) begin
         drive_en_r <= 1'b0;
      end else if (step_due) begin
         drive_en_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Coil pattern register; idle drops every phase to save coil heating.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         coil_r <= valve_step_pkg::COIL_OFF;
      end else if (state_r == valve_step_pkg::ST_IDLE || !drive_en_r) begin
         coil_r <= valve_step_pkg::COIL_OFF;
      end else begin
         case (phase_r)
            2'h0:    coil_r <= valve_step_pkg::COIL_STATE1;
            2'h1:    coil_r <= valve_step_pkg::COIL_STATE2;
            2'h2:    coil_r <= valve_step_pkg::COIL_STATE3;
            default: coil_r <= valve_step_pkg::COIL_STATE4;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status outputs, all registered.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         busy  <= 1'b1;
         homed <= 1'b0;
      end else begin
         busy  <= (state_r != valve_step_pkg::ST_IDLE);
         homed <= homed | (state_r != valve_step_pkg::ST_HOME);
      end
   end

   assign coil     = coil_r;
   assign position = pos_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_coil_two_adj : assert property (@(posedge clk_sys) disable iff (!nrst)
      coil inside {4'h0, 4'h3, 4'h6, 4'hC, 4'h9})
      else $error("Coil pattern is not a legal two-phase state.");

   a_idle_coil_off : assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_r == valve_step_pkg::ST_IDLE) |=> (coil == 4'h0))
      else $error("Coil energized while idle.");

   a_step_adjacent : assert property (@(posedge clk_sys) disable iff (!nrst)
      (coil != 4'h0 && $past(coil) != 4'h0 && coil != $past(coil)) |->
      ($countones(coil & $past(coil)) == 1))
      else $error("Coil sequence skipped a state.");

   a_close_dir : assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_r == valve_step_pkg::ST_MOVE && step_due && dir_close) |=>
      (phase_r == $past(phase_r) + 2'h1))
      else $error("Closing step went the wrong way.");

   a_pos_track : assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_r == valve_step_pkg::ST_MOVE && step_due && target_r != pos_r) |=>
      (pos_r != $past(pos_r)))
      else $error("Position did not follow a step.");

   a_home_first : assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_r == valve_step_pkg::ST_HOME) |-> (pos_r == 16'sh0000 && !homed))
      else $error("Motion before homing completed.");

   a_step_period : assert property (@(posedge clk_sys) disable iff (!nrst)
      step_due |=> !step_due)
      else $error("Steps issued back to back.");

   // Opening must walk the patterns backwards, one neighbour at a time.
   a_open_dir : assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_r == valve_step_pkg::ST_MOVE && step_due && !dir_close && target_r != pos_r) |=>
      (phase_r == $past(phase_r) - 2'h1))
      else $error("Opening step went the wrong way.");

   // No step may happen while nothing is commanded.
   a_idle_no_step : assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_r == valve_step_pkg::ST_IDLE) |=> $stable(phase_r))
      else $error("Phase moved while idle.");

   // A new run starts with the coils off until its first step.
   a_run_start_off : assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_r == valve_step_pkg::ST_IDLE ##1 state_r == valve_step_pkg::ST_MOVE) |=> (coil == 4'h0))
      else $error("Coil energized before the first step of a run.");

   // The homing run never counts past its length.
   a_home_len : assert property (@(posedge clk_sys) disable iff (!nrst)
      home_cnt_r <= 16'(HOME_STEPS))
      else $error("Homing count ran past its length.");

   // Homing ends on a step slot after the full count, at the closed reference.
   a_home_exit : assert property (@(posedge clk_sys) disable iff (!nrst)
      (state_r == valve_step_pkg::ST_HOME && step_due && home_cnt_r == 16'(HOME_STEPS)) |=>
      (state_r == valve_step_pkg::ST_IDLE && pos_r == valve_step_pkg::POS_CLOSED))
      else $error("Homing did not end at the closed reference.");

   // Once homed, the flag stays up until the next reset.
   a_homed_sticky : assert property (@(posedge clk_sys) disable iff (!nrst)
      homed |=> homed)
      else $error("Homed flag dropped.");

   // Busy mirrors the sequencer one cycle late.
   a_busy_state : assert property (@(posedge clk_sys) disable iff (!nrst)
      1'b1 |=> (busy == $past(state_r != valve_step_pkg::ST_IDLE)))
      else $error("Busy does not follow the sequencer.");

   // The interval counter stays inside its period.
   a_tick_bound : assert property (@(posedge clk_sys) disable iff (!nrst)
      tick_r < 32'(STEP_CYCLES))
      else $error("Step interval counter overran.");

endmodule : expansion_valve_drive

// [rtl/valve_step_pkg.sv]
package valve_step_pkg;

   // Coil drive patterns, bit 0 = phase A .. bit 3 = phase D.
   localparam logic [3:0] COIL_OFF     = 4'h0;
   localparam logic [3:0] COIL_STATE1  = 4'h3;  // A and B.
   localparam logic [3:0] COIL_STATE2  = 4'h6;  // B and C.
   localparam logic [3:0] COIL_STATE3  = 4'hC;  // C and D.
   localparam logic [3:0] COIL_STATE4  = 4'h9;  // D and A.

   // Power-on homing run length in steps.
   localparam int unsigned HOME_STEPS  = 2200;
   // Default step interval in microseconds and its count of 25 ns cycles.
   localparam int unsigned CLK_MHZ         = 40;
   localparam int unsigned STEP_PERIOD_US  = 2000;
   localparam int unsigned STEP_CYCLES     = STEP_PERIOD_US * CLK_MHZ;
   // Position reference after homing.
   localparam logic signed [15:0] POS_CLOSED = 16'sh0000;

   typedef enum logic [1:0] {
      ST_HOME = 2'b00,
      ST_IDLE = 2'b01,
      ST_MOVE = 2'b10
   } drive_state_t;

   // Position command carried as one bundle.
   typedef struct packed {
      logic               valid;
      logic signed [15:0] target;
   } pos_cmd_t;

endpackage : valve_step_pkg

// [dv/valve_motor_model.sv]
`timescale 1ns/1ps
// Four-coil valve motor: follows the rotor phase and counts net steps, closing negative.
module valve_motor_model #(
   parameter int unsigned STEP_CYCLES = 4
) (
   input  wire logic       clk_sys,
   input  wire logic [3:0] coil,
   output int              steps,
   output int              bad
);
   int         last_idx = 3;
   int         gap      = 0;
   int         idx;
   logic [3:0] prev     = 4'h0;

   function automatic int phase_of(input logic [3:0] c);
      case (c)
         4'h3: return 0;
         4'h6: return 1;
         4'hC: return 2;
         4'h9: return 3;
         default: return -1;
      endcase
   endfunction : phase_of

   // The rotor starts one phase behind AB, so the first homing pattern counts as one closing step.
   initial begin
      steps = 0;
      bad   = 0;
   end

   // A real rotor stalls on a skipped phase, so any jump other than one neighbour is a fault.
   always @(posedge clk_sys) begin
      idx = phase_of(coil);
      gap = gap + 1;
      if (coil !== prev && coil !== 4'h0) begin
         if (idx < 0) bad++;
         else begin
            if (prev !== 4'h0 && gap != STEP_CYCLES) bad++;
            case ((idx - last_idx + 4) % 4)
               1: steps--;
               3: steps++;
               default: bad++;
            endcase
            last_idx = idx;
         end
         gap = 0;
      end
      prev = coil;
   end
endmodule : valve_motor_model

// [dv/expansion_valve_drive_bench.sv]
`timescale 1ns/1ps
module expansion_valve_drive_bench;
   localparam int unsigned STEPS = 4;
   localparam int unsigned HOMES = 5;
   logic                     clk_sys;
   logic                     nrst;
   valve_step_pkg::pos_cmd_t cmd;
   logic [3:0]               coil;
   logic signed [15:0]       position;
   logic                     busy;
   logic                     homed;
   int                       motor_steps;
   int                       motor_bad;
   int                       base;
   int                       fails    = 0;
   int                       n_checks = 0;

   expansion_valve_drive #(.STEP_CYCLES(STEPS), .HOME_STEPS(HOMES)) u_expansion_valve_drive (.clk_sys(clk_sys),
      .nrst(nrst), .cmd(cmd), .coil(coil), .position(position), .busy(busy), .homed(homed));
   valve_motor_model #(.STEP_CYCLES(STEPS)) u_valve_motor_model (.clk_sys(clk_sys), .coil(coil),
      .steps(motor_steps), .bad(motor_bad));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Free-running 40 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task summarize;
      if (fails == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize

   // Bounded wait for a finished homing run or move; a hang ends the run.
   task wait_idle;
      int i;
      for (i = 0; i < 400; i++) begin
         @(negedge clk_sys);
         if (homed === 1'b1 && busy === 1'b0) break;
      end
      if (i == 400) begin
         fails++;
         summarize();
      end
   endtask : wait_idle

   task pulse(input logic signed [15:0] tgt);
      @(negedge clk_sys);
      cmd.valid  = 1'b1;
      cmd.target = tgt;
      @(negedge clk_sys);
      cmd.valid  = 1'b0;
   endtask : pulse

   task move(input logic signed [15:0] tgt, input int exp_delta);
      pulse(tgt);
      repeat (3) @(negedge clk_sys);
      wait_idle();
      check("position", 32'(position), 32'(tgt));
      check("net steps", motor_steps - base, exp_delta);
      check("coil idle", {28'h0, coil}, 32'h0);
   endtask : move

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Homing ignores a command, then open, close past zero and a retarget in flight.
   initial begin
      nrst = 1'b0;
      cmd  = '0;
      repeat (16) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (STEPS + 2) @(negedge clk_sys);
      check("homing busy", {31'h0, busy}, 32'h1);
      pulse(16'sh0007);
      wait_idle();
      check("home position", 32'(position), 32'h0);
      check("home steps", motor_steps, -HOMES);
      check("home coil", {28'h0, coil}, 32'h0);
      base = motor_steps;
      move(16'sh0003, 3);
      base = motor_steps;
      move(-16'sh0002, -5);
      base = motor_steps;
      pulse(16'sh0006);
      repeat (6 * STEPS) @(negedge clk_sys);
      move(16'sh0001, 3);
      check("motor faults", motor_bad, 0);
      summarize();
   end
endmodule : expansion_valve_drive_bench
